//--- hw/bbd_core.sv
// Decode and execute of relative jump, bit set and bit-test skips
`timescale 1ns/100ps
// Function
// - Opcode 11010 with signed 11-bit offset
// - Jump target is fetched PC plus 2n
// - Jump takes two cycles, second is idle
// - No status flag is ever modified
// - Bit-set writes one into chosen bit
// - Bank flag picks access bank or bank choice
// - Indexed literal-offset mode for low access addresses
// - Matching skip discards next fetched instruction
`include "bbd_regs.svh"
module bbd_core (
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    // Program memory
    input  wire logic [15:0]          i_instr,
    output logic      [20:0]          o_pc,
    output logic                      o_fetch,
    // Core context
    input  wire logic [3:0]           i_bank_choice_register,
    input  wire logic                 i_ext_set_en,
    input  wire logic [11:0]          i_index_base,
    // File register port
    input  wire logic [7:0]           i_file_rdata,
    output logic      [11:0]          o_file_raddr,
    output bbd_pkg::bbd_fwr_type      o_file_wr,
    output logic      [1:0]           o_phase
);
    import bbd_pkg::*;

    bbd_state_type st_r;
    bbd_state_type st_nxt;

    logic        is_jump;
    logic        is_set;
    logic        is_skip;
    logic        is_skip_high;
    logic [2:0]  b_field;
    logic [7:0]  f_field;
    logic [20:0] offset2;
    logic [20:0] jump_pc;
    logic        use_bank_reg;
    logic        use_indexed;
    logic        use_access_hi;
    logic [11:0] addr_calc;
    logic [7:0]  set_mask;
    logic [7:0]  set_data;
    logic [7:0]  test_hits;
    logic        bit_val;
    logic        jump_taken;
    logic        skip_taken;

    // ------------------------------------------------------------------
    // Opcode decode
    // ------------------------------------------------------------------
    // Only the latched word is decoded; i_instr is not looked at
    // until it is taken at the end of Q4
    always_comb begin
        is_jump      = (st_r.ir[15:11] == `BBD_OP_JUMP);
        is_set       = (st_r.ir[15:12] == `BBD_OP_SETBIT);
        is_skip_high = (st_r.ir[15:12] == `BBD_OP_SKIP_HIGH);
        is_skip      = (st_r.ir[15:12] == `BBD_OP_SKIP_LOW)
                       || is_skip_high;
        b_field      = st_r.ir[11:9];
        f_field      = st_r.ir[7:0];
    end

    // ------------------------------------------------------------------
    // Jump target
    // ------------------------------------------------------------------
    // The fetch address is already one word past the jump, so the
    // offset is added to it as it stands
    always_comb begin
        // Sign-extended word offset doubled into a byte offset
        offset2 = {{9{st_r.ir[10]}}, st_r.ir[10:0], 1'b0};
        jump_pc = st_r.pc + offset2;
    end

    // ------------------------------------------------------------------
    // File address
    // ------------------------------------------------------------------
    // Indexed mode wins over the access bank for low addresses;
    // the sum wraps inside the 12-bit file space
    always_comb begin
        use_bank_reg  = st_r.ir[8];
        use_indexed   = !st_r.ir[8] && i_ext_set_en
                        && (f_field <= `BBD_IDX_LIMIT);
        use_access_hi = !st_r.ir[8] && f_field[7];
        if (use_bank_reg) begin
            addr_calc = {i_bank_choice_register, f_field};
        end else if (use_indexed) begin
            addr_calc = i_index_base + {`BBD_ACCESS_LO, f_field};
        end else if (use_access_hi) begin
            addr_calc = {`BBD_ACCESS_HI, f_field};
        end else begin
            addr_calc = {`BBD_ACCESS_LO, f_field};
        end
    end

    // ------------------------------------------------------------------
    // Bit select
    // ------------------------------------------------------------------
    // One slice per data bit; the chosen bit drives set and test alike
    generate
        for (genvar gi = 0; gi < 8; gi++) begin : g_bit
            assign set_mask[gi]  = (st_r.bit_sel == 3'(gi));
            assign set_data[gi]  = st_r.fdata[gi] | set_mask[gi];
            assign test_hits[gi] = set_mask[gi] & st_r.fdata[gi];
        end
    endgenerate

    assign bit_val = |test_hits;

    // ------------------------------------------------------------------
    // Flow change
    // ------------------------------------------------------------------
    // A flushed jump must not redirect, or the discarded slot would
    // still steer the program
    always_comb begin
        jump_taken = !st_r.flush && is_jump;
        skip_taken = st_r.exec_skip
                     && (bit_val == st_r.skip_high);
    end

    // ------------------------------------------------------------------
    // Status
    // ------------------------------------------------------------------
    // No flag register lives here: none of the three instructions leaves anything
    // behind but the file write and the fetch address

    // ------------------------------------------------------------------
    // Phase sequencer
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt        = st_r;
        st_nxt.fwr.we = 1'b0;
        st_nxt.fetch  = 1'b0;
        case (st_r.phase)
            Q1: begin
                // Decode
                st_nxt.phase     = Q2;
                st_nxt.exec_set  = 1'b0;
                st_nxt.exec_skip = 1'b0;
                // Flushed slot runs as a no-operation
                if (!st_r.flush) begin
                    st_nxt.exec_set  = is_set;
                    st_nxt.exec_skip = is_skip;
                    st_nxt.skip_high = is_skip_high;
                    st_nxt.bit_sel   = b_field;
                    st_nxt.faddr     = addr_calc;
                end
            end
            Q2: begin
                // Read register
                st_nxt.phase = Q3;
                st_nxt.fdata = i_file_rdata;
            end
            Q3: begin
                // Modify
                st_nxt.phase = Q4;
                if (st_r.exec_set) begin
                    st_nxt.fdata = set_data;
                end
            end
            default: begin
                // Write back, fetch and redirect
                st_nxt.phase = Q1;
                st_nxt.flush = 1'b0;
                st_nxt.ir    = i_instr;
                st_nxt.fetch = 1'b1;
                st_nxt.pc    = st_r.pc + `BBD_PC_STEP;
                if (jump_taken) begin
                    st_nxt.pc    = jump_pc;
                    st_nxt.flush = 1'b1;
                    st_nxt.fetch = 1'b0;
                end else if (skip_taken) begin
                    st_nxt.flush = 1'b1;
                end
                if (st_r.exec_set) begin
                    st_nxt.fwr.we   = 1'b1;
                    st_nxt.fwr.addr = st_r.faddr;
                    st_nxt.fwr.data = st_r.fdata;
                end
            end
        endcase
        // Reset parks the core in Q1 with the first slot flushed, so
        // the word taken at the first Q4 runs one cycle later
        if (!i_rst_n) begin
            st_nxt          = '0;
            st_nxt.phase    = Q1;
            st_nxt.flush    = 1'b1;
            st_nxt.pc       = `BBD_PC_RESET;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        st_r <= st_nxt;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_comb begin
        o_pc         = st_r.pc;
        o_fetch      = st_r.fetch;
        o_file_raddr = st_r.faddr;
        o_file_wr    = st_r.fwr;
        o_phase      = st_r.phase;
    end
endmodule

//--- hw/bbd_pkg.sv
// Types for the branch and bit-set decode block
package bbd_pkg;
    typedef enum logic [1:0] {Q1, Q2, Q3, Q4} bbd_phase_type;

    typedef struct packed {
        logic        we;
        logic [11:0] addr;
        logic [7:0]  data;
    } bbd_fwr_type;

    typedef struct packed {
        bbd_phase_type phase;
        logic          flush;
        logic [20:0]   pc;
        logic [15:0]   ir;
        logic [11:0]   faddr;
        logic [7:0]    fdata;
        logic          exec_set;
        logic          exec_skip;
        logic          skip_high;
        logic [2:0]    bit_sel;
        bbd_fwr_type   fwr;
        logic          fetch;
    } bbd_state_type;
endpackage

//--- hw/bbd_regs.svh
// Constants for the branch and bit-set decode block
`ifndef BBD_REGS_SVH
`define BBD_REGS_SVH
`define BBD_OP_JUMP        5'h1a
`define BBD_OP_SETBIT      4'h8
`define BBD_OP_SKIP_LOW    4'hb
`define BBD_OP_SKIP_HIGH   4'ha
`define BBD_IDX_LIMIT      8'h5f
`define BBD_ACCESS_HI      4'hf
`define BBD_ACCESS_LO      4'h0
`define BBD_PC_RESET       21'h000000
`define BBD_PC_STEP        21'h000002
`endif

//--- tb/bbd_core_properties.sv
// Timing checks on the ports of the decode block
`timescale 1ns/100ps
module bbd_chk (
    input wire logic                 i_clk,
    input wire logic                 i_rst_n,
    input wire logic [7:0]           i_file_rdata,
    input wire logic [20:0]          o_pc,
    input wire logic                 o_fetch,
    input wire logic [11:0]          o_file_raddr,
    input wire bbd_pkg::bbd_fwr_type o_file_wr,
    input wire logic [1:0]           o_phase
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    AST_WE_Q1: assert property (o_file_wr.we |-> o_phase == 2'h0)
        else $error("write strobe outside first phase");
    AST_WE_PULSE: assert property (o_file_wr.we |=> !o_file_wr.we)
        else $error("write strobe longer than one clock");
    AST_SET_BIT: assert property (o_file_wr.we |->
        $countones(o_file_wr.data ^ $past(i_file_rdata, 3)) <= 1 &&
        (o_file_wr.data & $past(i_file_rdata, 3)) == $past(i_file_rdata, 3))
        else $error("write data is not read data plus one bit");
    AST_ADDR: assert property (o_file_wr.we |->
        o_file_wr.addr == $past(o_file_raddr))
        else $error("write address differs from read address");
    AST_FETCH_Q1: assert property (o_fetch |-> o_phase == 2'h0)
        else $error("fetch pulse outside first phase");
    AST_PC_HOLD: assert property (o_phase != 2'h0 |-> $stable(o_pc))
        else $error("fetch address moved mid cycle");
    AST_PC_STEP: assert property (o_fetch |->
        o_pc == $past(o_pc) + 21'h2)
        else $error("fetch address not one word on");
    AST_JUMP_NOP: assert property (o_phase == 2'h0 && !o_fetch |->
        ##4 !o_file_wr.we)
        else $error("discarded slot wrote a register");
    AST_PHASE: assert property (o_phase == 2'h3 |=>
        o_phase == 2'h0 ##1 o_phase == 2'h1)
        else $error("phase order broken");
endmodule
bind bbd_core bbd_chk u_chk (.*);

//--- tb/test_bbd_core.sv
// Self-checking bench for the decode block
`timescale 1ns/100ps
module test_bbd_core;
    logic                 i_clk = 0;
    logic                 i_rst_n = 0;
    logic                 i_ext_set_en = 1;
    logic [3:0]           i_bank_choice_register = 4'h3;
    logic [11:0]          i_index_base = 12'h100;
    logic [15:0]          i_instr = 16'h0;
    logic [7:0]           i_file_rdata = 8'h0;
    logic [20:0]          o_pc;
    logic                 o_fetch;
    logic [11:0]          o_file_raddr;
    logic [1:0]           o_phase;
    bbd_pkg::bbd_fwr_type o_file_wr;
    // Words at 6 and 14 must never execute
    logic [15:0] rom [9] = '{16'h8a55, 16'h8f12, 16'hd002, 16'h8001,
        16'h0, 16'h8480, 16'ha080, 16'h8e00, 16'hd7f7};
    int miscompares = 0;
    int num_checks = 0;
    bbd_core DUT (.*);
    initial forever #4 i_clk = ~i_clk;
    always @(negedge i_clk) begin
        i_instr <= rom[o_pc[4:1]];
        i_file_rdata <= (o_file_raddr == 12'hf80) ? 8'h0b : 8'h0a;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask
    task automatic expect_wr(input logic [19:0] exp);
        int n;
        n = 0;
        do @(negedge i_clk); while (o_file_wr.we !== 1'b1 && ++n < 40);
        check(32'(o_file_wr.we), 32'h1);
        check(32'({o_file_wr.addr, o_file_wr.data}), 32'(exp));
    endtask
    task automatic sc_bitset;
        expect_wr({12'h155, 8'h2a});
        expect_wr({12'h312, 8'h8a});
    endtask
    task automatic sc_jump;
        int n;
        n = 0;
        do @(negedge i_clk);
        while ((o_phase !== 2'h0 || o_fetch !== 1'b0) && ++n < 40);
        check(32'(o_pc), 32'ha);
        repeat (4) @(negedge i_clk);
        check(32'({o_phase, o_fetch}), 32'h1);
        check(32'(o_pc), 32'hc);
        expect_wr({12'hf80, 8'h0f});
    endtask
    task automatic sc_reset;
        @(negedge i_clk);
        i_rst_n <= 0;
        repeat (2) @(negedge i_clk);
        check(32'({o_pc, o_phase, o_fetch, o_file_wr.we}), 32'h0);
        i_rst_n <= 1;
        @(negedge i_clk);
        check(32'({o_phase, o_fetch}), 32'h2);
        expect_wr({12'h155, 8'h2a});
    endtask
    task automatic sc_skip;
        expect_wr({12'h155, 8'h2a});
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge i_clk);
        i_rst_n <= 1;
        sc_bitset();
        sc_jump();
        sc_skip();
        sc_reset();
        end_sim();
    end
    initial begin
        #20000;
        miscompares++;
        end_sim();
    end
endmodule
